// ---- bench/cfs_roll_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module cfs_roll_model
    import cfs_pkg::*;
(
    input wire logic core_clk,
    input wire logic hold_roll,
    input wire logic go,
    input wire logic homing,
    input wire logic with_pulse,
    input wire logic away,
    output var cfs_motion_t motion
);
    logic [2:0] step = 3'h0;
    // A held roll stands still, so no new cycle starts
    always_ff @(posedge core_clk) begin
        if (step != 3'h0) begin
            step <= (step == 3'h5) ? 3'h0 : step + 3'h1;
        end else if (go && !hold_roll) begin
            step <= 3'h1;
        end
    end
    always_comb begin
        motion.cut_pulse = with_pulse && step == 3'h3;
        motion.homing = homing;
        motion.rev_done = homing && step == 3'h5;
        motion.sync_zone = !homing && step >= 3'h2;
        motion.cycle_start = step == 3'h1;
        motion.at_home = !away;
        motion.cut_done = !homing && step == 3'h5;
    end
endmodule
`default_nettype wire

// ---- bench/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
    $display("mismatch %s expected %0h seen %0h", nm, e, g); end end
module tb_top
    import cfs_pkg::*;
;
    logic core_clk, rstn, virt_pulse, mark_detect, mark_consume, clear_cmd, run_permit;
    logic hw_check_fail, supply_low, go, homing, with_pulse, away;
    logic virt_marker, fault_out, hold_roll;
    logic [15:0] index_interval, master_freq, cs, fs;
    logic [16:0] cg, fg;
    logic [4:0] fault_code, fault_flags;
    cfs_motion_t motion;
    int fail_count = 0;
    int num_checks = 0;
    int markers = 0;
    cfs_supervisor dut (.core_clk(core_clk), .rstn(rstn), .virt_pulse(virt_pulse),
        .index_interval(index_interval), .virt_marker(virt_marker),
        .master_freq(master_freq), .cutter_feedforward_gain(cg),
        .feeder_feedforward_gain(fg), .cutter_ff_speed(cs), .feeder_ff_speed(fs),
        .motion(motion), .hw_check_fail(hw_check_fail), .supply_low(supply_low),
        .mark_detect(mark_detect), .mark_consume(mark_consume), .clear_cmd(clear_cmd),
        .run_permit(run_permit), .fault_out(fault_out), .fault_code(fault_code),
        .fault_flags(fault_flags), .hold_roll(hold_roll));
    cfs_roll_model roll (.core_clk(core_clk), .hold_roll(hold_roll), .go(go),
        .homing(homing), .with_pulse(with_pulse), .away(away), .motion(motion));
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        if (virt_marker === 1'b1) markers++;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic cut_cycle();
        go = 1'b1;
        tick(1);
        go = 1'b0;
        tick(7);
    endtask
    task automatic clr();
        clear_cmd = 1'b1;
        tick(1);
        clear_cmd = 1'b0;
        tick(1);
    endtask
    task automatic chk_f(input logic [4:0] fl, input logic [4:0] cd);
        `CHK("fault_flags", fl, fault_flags)
        `CHK("fault_code", cd, fault_code)
        `CHK("fault_out", fl != 5'h00, fault_out)
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Whole sequence needs well under 1000 cycles
    initial begin
        repeat (3000) @(posedge core_clk);
        fail_count++;
        complete_run();
    end
    initial begin
        {rstn, virt_pulse, mark_detect, mark_consume, clear_cmd, hw_check_fail} = '0;
        {supply_low, go, homing, with_pulse, away} = '0;
        run_permit = 1'b1;
        index_interval = 16'h0003;
        master_freq = 16'h03E8;
        cg = 17'h04E20;
        fg = 17'h01388;
        tick(20);
        rstn = 1'b1;
        tick(2);
        chk_f(5'h00, 5'h00);
        `CHK("cutter_ff_speed", 16'h07D0, cs)
        `CHK("feeder_ff_speed", 16'h01F4, fs)
        master_freq = 16'hFFFF;
        cg = 17'h1869F;
        fg = 17'h1869F;
        tick(2);
        `CHK("cutter_ff_speed", 16'hFFFF, cs)
        `CHK("feeder_ff_speed", 16'hFFFF, fs)
        virt_pulse = 1'b1;
        tick(9);
        virt_pulse = 1'b0;
        tick(2);
        `CHK("markers", 3, markers)
        index_interval = 16'h0000;
        virt_pulse = 1'b1;
        tick(9);
        virt_pulse = 1'b0;
        tick(2);
        `CHK("markers", 3, markers)
        with_pulse = 1'b1;
        cut_cycle();
        chk_f(5'h00, 5'h00);
        go = 1'b1;
        tick(1);
        go = 1'b0;
        supply_low = 1'b1;
        tick(1);
        chk_f(5'h02, 5'h01);
        `CHK("hold_roll", 1'b0, hold_roll)
        tick(5);
        `CHK("hold_roll", 1'b1, hold_roll)
        clr();
        chk_f(5'h02, 5'h01);
        supply_low = 1'b0;
        tick(2);
        chk_f(5'h00, 5'h00);
        `CHK("hold_roll", 1'b0, hold_roll)
        with_pulse = 1'b0;
        cut_cycle();
        chk_f(5'h04, 5'h02);
        `CHK("hold_roll", 1'b1, hold_roll)
        run_permit = 1'b0;
        tick(2);
        run_permit = 1'b1;
        chk_f(5'h00, 5'h00);
        homing = 1'b1;
        cut_cycle();
        chk_f(5'h04, 5'h02);
        `CHK("hold_roll", 1'b0, hold_roll)
        clr();
        chk_f(5'h00, 5'h00);
        homing = 1'b0;
        with_pulse = 1'b1;
        away = 1'b1;
        cut_cycle();
        chk_f(5'h08, 5'h03);
        `CHK("hold_roll", 1'b0, hold_roll)
        away = 1'b0;
        clr();
        mark_detect = 1'b1;
        tick(8);
        mark_detect = 1'b0;
        tick(2);
        chk_f(5'h00, 5'h00);
        mark_detect = 1'b1;
        tick(1);
        mark_detect = 1'b0;
        tick(2);
        chk_f(5'h10, 5'h04);
        mark_consume = 1'b1;
        tick(8);
        mark_consume = 1'b0;
        clr();
        chk_f(5'h00, 5'h00);
        hw_check_fail = 1'b1;
        supply_low = 1'b1;
        tick(1);
        hw_check_fail = 1'b0;
        tick(1);
        chk_f(5'h03, 5'h00);
        supply_low = 1'b0;
        clr();
        run_permit = 1'b0;
        tick(2);
        run_permit = 1'b1;
        chk_f(5'h01, 5'h00);
        `CHK("hold_roll", 1'b0, hold_roll)
        rstn = 1'b0;
        tick(2);
        rstn = 1'b1;
        tick(1);
        chk_f(5'h00, 5'h00);
        complete_run();
    end
endmodule
`default_nettype wire

// ---- include/cfs_pkg.sv ----
package cfs_pkg;
    localparam int CFS_NFAULT = 5;
    localparam logic [4:0] CFS_CODE_HW = 5'h00;
    localparam logic [4:0] CFS_CODE_PWR = 5'h01;
    localparam logic [4:0] CFS_CODE_NOCUT = 5'h02;
    localparam logic [4:0] CFS_CODE_HOME = 5'h03;
    localparam logic [4:0] CFS_CODE_MARK = 5'h04;
    localparam int CFS_F_HW = 0;
    localparam int CFS_F_PWR = 1;
    localparam int CFS_F_NOCUT = 2;
    localparam int CFS_F_HOME = 3;
    localparam int CFS_F_MARK = 4;
    // Faults that stop the roll; 00 and 03 only report
    localparam logic [4:0] CFS_STOP_MASK = 5'h16;
    localparam logic [15:0] CFS_INDEX_RST = 16'h0000;
    // Gain is 0.0001 .. 9.9999 in units of 0.0001
    localparam logic [16:0] CFS_GAIN_MAX = 17'h1869F;
    localparam logic [16:0] CFS_GAIN_RST = 17'h02710;
    localparam logic [16:0] CFS_GAIN_SCALE = 17'h02710;
    localparam int CFS_MARK_DEPTH = 8;
    localparam logic [3:0] CFS_MARK_RST = 4'h0;
    typedef struct packed {
        logic cut_pulse;
        logic homing;
        logic rev_done;
        logic sync_zone;
        logic cycle_start;
        logic at_home;
        logic cut_done;
    } cfs_motion_t;
    typedef enum logic [2:0] {
        CFS_RUN = 3'b001,
        CFS_FINISH = 3'b010,
        CFS_HOLD = 3'b100
    } cfs_state_t;
endpackage

// ---- src/cfs_ff_scale.sv ----
`timescale 1ns/1ps
`default_nettype none
module cfs_ff_scale
    import cfs_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [15:0] master_freq,
    input wire logic [16:0] gain,
    output logic [15:0] speed
);
    logic [16:0] gain_lim;
    logic [32:0] prod;
    logic [32:0] quot;
    logic [32:0] sat;
    // Gain above the range clamps to the top of the range
    assign gain_lim = (gain > CFS_GAIN_MAX) ? CFS_GAIN_MAX : gain;
    assign prod = {17'h00000, master_freq} * {16'h0000, gain_lim};
    assign quot = prod / {16'h0000, CFS_GAIN_SCALE};
    assign sat = (quot > 33'h00000FFFF) ? 33'h00000FFFF : quot;
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            speed <= 16'h0000;
        end else begin
            speed <= sat[15:0];
        end
    end
endmodule
`default_nettype wire

// ---- src/cfs_supervisor.sv ----
`timescale 1ns/1ps
`default_nettype none
module cfs_supervisor
    import cfs_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic virt_pulse,
    input wire logic [15:0] index_interval,
    output logic virt_marker,
    input wire logic [15:0] master_freq,
    input wire logic [16:0] cutter_feedforward_gain,
    input wire logic [16:0] feeder_feedforward_gain,
    output logic [15:0] cutter_ff_speed,
    output logic [15:0] feeder_ff_speed,
    input wire cfs_motion_t motion,
    input wire logic hw_check_fail,
    input wire logic supply_low,
    input wire logic mark_detect,
    input wire logic mark_consume,
    input wire logic clear_cmd,
    input wire logic run_permit,
    output logic fault_out,
    output logic [4:0] fault_code,
    output logic [4:0] fault_flags,
    output logic hold_roll
);
    logic [15:0] index_cnt;
    logic [3:0] mark_cnt;
    logic [4:0] next_flags;
    logic [4:0] raise;
    logic [4:0] clr_mask;
    logic [4:0] next_code;
    logic clear_any;
    logic cut_seen;
    logic mark_ovf;
    logic mark_inc;
    logic mark_dec;
    logic index_hit;
    cfs_state_t state;
    cfs_state_t next_state;

    // Zero interval never fires; the counter would otherwise fire only on reaching FFFF
    assign index_hit = virt_pulse && (index_interval != 16'h0000)
        && (index_cnt == index_interval - 16'h0001);
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            index_cnt <= CFS_INDEX_RST;
            virt_marker <= 1'b0;
        end else begin
            virt_marker <= index_hit;
            if (index_hit) begin
                index_cnt <= 16'h0000;
            end else if (virt_pulse) begin
                index_cnt <= index_cnt + 16'h0001;
            end
        end
    end

    cfs_ff_scale u_cut_ff (
        .core_clk(core_clk),
        .rstn(rstn),
        .master_freq(master_freq),
        .gain(cutter_feedforward_gain),
        .speed(cutter_ff_speed)
    );
    cfs_ff_scale u_feed_ff (
        .core_clk(core_clk),
        .rstn(rstn),
        .master_freq(master_freq),
        .gain(feeder_feedforward_gain),
        .speed(feeder_ff_speed)
    );

    assign mark_inc = mark_detect && !mark_consume;
    assign mark_dec = mark_consume && !mark_detect && (mark_cnt != 4'h0);
    assign mark_ovf = mark_inc && (mark_cnt == 4'(CFS_MARK_DEPTH));
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            mark_cnt <= CFS_MARK_RST;
        end else if (mark_inc && !mark_ovf) begin
            mark_cnt <= mark_cnt + 4'h1;
        end else if (mark_dec) begin
            mark_cnt <= mark_cnt - 4'h1;
        end
    end

    // Cut pulse seen since homing or sync zone began
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            cut_seen <= 1'b0;
        end else if (motion.cut_pulse) begin
            cut_seen <= 1'b1;
        end else if (!motion.homing && !motion.sync_zone) begin
            cut_seen <= 1'b0;
        end
    end

    assign raise[CFS_F_HW] = hw_check_fail;
    assign raise[CFS_F_PWR] = supply_low;
    assign raise[CFS_F_NOCUT] = !motion.cut_pulse && !cut_seen
        && ((motion.homing && motion.rev_done) || (motion.sync_zone && motion.cut_done));
    assign raise[CFS_F_HOME] = motion.cycle_start && !motion.at_home;
    assign raise[CFS_F_MARK] = mark_ovf;

    assign clear_any = clear_cmd || !run_permit;
    // hardware fault survives all but reset; supply self-clears
    assign clr_mask = {clear_any, clear_any, clear_any, !supply_low, 1'b0};
    assign next_flags = (fault_flags & ~clr_mask) | raise;

    always_comb begin
        next_code = CFS_CODE_HW;
        if (next_flags[CFS_F_HW]) begin
            next_code = CFS_CODE_HW;
        end else if (next_flags[CFS_F_PWR]) begin
            next_code = CFS_CODE_PWR;
        end else if (next_flags[CFS_F_NOCUT]) begin
            next_code = CFS_CODE_NOCUT;
        end else if (next_flags[CFS_F_HOME]) begin
            next_code = CFS_CODE_HOME;
        end else if (next_flags[CFS_F_MARK]) begin
            next_code = CFS_CODE_MARK;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            fault_flags <= 5'h00;
            fault_out <= 1'b0;
            fault_code <= CFS_CODE_HW;
        end else begin
            fault_flags <= next_flags;
            fault_out <= |next_flags;
            fault_code <= next_code;
        end
    end

    always_comb begin
        next_state = state;
        unique case (state)
            CFS_RUN: begin
                if (|(next_flags & CFS_STOP_MASK)) begin
                    next_state = motion.cut_done ? CFS_HOLD : CFS_FINISH;
                end
            end
            CFS_FINISH: begin
                // A fault cleared before the cut ends must not hold a later cycle
                if (!(|(next_flags & CFS_STOP_MASK))) begin
                    next_state = CFS_RUN;
                end else if (motion.cut_done) begin
                    next_state = CFS_HOLD;
                end
            end
            CFS_HOLD: begin
                if (!(|(next_flags & CFS_STOP_MASK))) begin
                    next_state = CFS_RUN;
                end
            end
            default: next_state = CFS_RUN;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            state <= CFS_RUN;
            hold_roll <= 1'b0;
        end else begin
            state <= next_state;
            hold_roll <= (next_state == CFS_HOLD);
        end
    end

    marker_period_a: assert property (@(posedge core_clk) disable iff (!rstn)
        index_hit |=> virt_marker) else $error("marker missing");
    fault_out_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (|fault_flags) == fault_out) else $error("fault output wrong");
    hw_sticky_a: assert property (@(posedge core_clk) disable iff (!rstn)
        fault_flags[CFS_F_HW] |=> fault_flags[CFS_F_HW]) else $error("hw fault lost");
    pwr_auto_a: assert property (@(posedge core_clk) disable iff (!rstn)
        !supply_low && !clear_any |=> !fault_flags[CFS_F_PWR])
        else $error("power fault stuck");
    clear_cmd_a: assert property (@(posedge core_clk) disable iff (!rstn)
        clear_any && !raise[CFS_F_MARK] |=> !fault_flags[CFS_F_MARK])
        else $error("clear ignored");
    set_wins_a: assert property (@(posedge core_clk) disable iff (!rstn)
        raise[CFS_F_NOCUT] |=> fault_flags[CFS_F_NOCUT]) else $error("set lost");
    home_nostop_a: assert property (@(posedge core_clk) disable iff (!rstn)
        fault_flags[CFS_F_HOME] && state == CFS_RUN && (next_flags & CFS_STOP_MASK) == 5'h00
        |=> !hold_roll)
        else $error("home fault stopped roll");
    overflow_a: assert property (@(posedge core_clk) disable iff (!rstn)
        mark_detect && !mark_consume && mark_cnt == 4'h8 |=> fault_flags[CFS_F_MARK])
        else $error("overflow missed");
    sequence stop_seen;
        state == CFS_RUN && (|(next_flags & CFS_STOP_MASK)) && !motion.cut_done;
    endsequence
    finish_first_a: assert property (@(posedge core_clk) disable iff (!rstn)
        stop_seen |=> !hold_roll) else $error("stopped mid cut");
    code_a: assert property (@(posedge core_clk) disable iff (!rstn)
        fault_flags == 5'h10 |-> fault_code == CFS_CODE_MARK) else $error("bad code");
endmodule
`default_nettype wire
